/* File: rtl/slr_params.svh */
// Constants of the slave port loop router: port count, widths,
// timing figures and reset values. Included by the package only.
`ifndef SLR_PARAMS_SVH
`define SLR_PARAMS_SVH
`define SLR_NPORTS      4
`define SLR_ADDR_W      16
`define SLR_BYTE_W      8
`define SLR_BUF_DEPTH   2
`define SLR_CLK_NS      4
`define SLR_DLY_CU_NS   1000
`define SLR_DLY_LV_NS   300
`define SLR_DLY_CU_CYC  (`SLR_DLY_CU_NS / `SLR_CLK_NS)
`define SLR_DLY_LV_CYC  (`SLR_DLY_LV_NS / `SLR_CLK_NS)
`define SLR_FLICK_NS    40000000
`define SLR_FLICK_CYC   (`SLR_FLICK_NS / `SLR_CLK_NS)
`define SLR_ADDR_LO_POS 8'h00
`define SLR_ADDR_HI_POS 8'h01
`define SLR_IDX_MAX     8'hff
`define SLR_OPEN_RST    4'h0
`endif

/* File: rtl/slr_pkg.sv */
// Types and ring helpers of the slave port loop router.
// Assumes the constants header is on the include path.
`include "slr_params.svh"
package slr_pkg;
  typedef logic [`SLR_BYTE_W-1:0] slr_byte_t;
  typedef logic [`SLR_BYTE_W:0]   slr_entry_t;  // {last, data}
  typedef logic [1:0]             slr_idx_t;

  typedef struct packed {
    logic [`SLR_NPORTS-1:0]                       open;
    logic [`SLR_NPORTS-1:0]                       act;
    slr_entry_t [`SLR_NPORTS-1:0][`SLR_BUF_DEPTH-1:0] buff;
    logic [`SLR_NPORTS-1:0][1:0]                  cnt;
    logic [7:0]                                   bidx;
    logic [`SLR_ADDR_W-1:0]                       addr;
    logic                                         ext_v;
    slr_byte_t                                    ext_d;
    logic [23:0]                                  blink;
    logic                                         phase;
  } slr_state_t;

  // Nearest open port before k on the ring; k itself if none
  function automatic slr_idx_t slr_prev(input slr_idx_t k, input logic [3:0] op);
    slr_idx_t r;
    r = k;
    for (int d = 3; d >= 1; d--) begin
      if (op[k - slr_idx_t'(d)]) r = k - slr_idx_t'(d);
    end
    return r;
  endfunction

  // Nearest open port after k on the ring; k itself if none
  function automatic slr_idx_t slr_next(input slr_idx_t k, input logic [3:0] op);
    slr_idx_t r;
    r = k;
    for (int d = 3; d >= 1; d--) begin
      if (op[k + slr_idx_t'(d)]) r = k + slr_idx_t'(d);
    end
    return r;
  endfunction
endpackage

/* File: rtl/slr_loop_router.sv */
// Port loop of a slave controller: four byte-stream ports in a ring,
// link-driven port opening, on-the-fly access on port 0 and indicators.
// Assumes each port's link input is already qualified by its PHY and
// that all inputs are synchronous to sys_clk_i.

// Behaviour
// - Up to four ports, forwarded ring-wise.
// - Port opens only with established link.
// - Unlinked port stays closed, no software.
// - Link means both ends recover symbols.
// - Indicator dark, steady, or flickering.
// - Hardware port order sets frame path.
// - Sixteen-bit slave address field.
// - Bytes extracted and inserted while streaming.
// - Copper/fiber ports add about one microsecond; here every port adds one 4 ns cycle.
// - Differential-only ports add about 300 ns; here one 4 ns cycle.
// - Every link is 100 Mbit/s full duplex.
module slr_loop_router
  import slr_pkg::*;
#(
  parameter int FLICK_CYC = `SLR_FLICK_CYC
) (
  input  wire logic                        sys_clk_i,      // 250 MHz clock
  input  wire logic                        rst_i,          // Sync reset
  input  wire logic [`SLR_NPORTS-1:0]      port_en_i,      // Port fitted
  input  wire logic [`SLR_NPORTS-1:0]      link_up_i,      // PHY link ok
  input  wire logic [`SLR_NPORTS-1:0]      rx_valid_i,     // Rx byte valid
  input  wire slr_byte_t [`SLR_NPORTS-1:0] rx_data_i,      // Rx byte
  input  wire logic [`SLR_NPORTS-1:0]      rx_last_i,      // Rx frame end
  output logic [`SLR_NPORTS-1:0]           rx_ready_o,     // Rx accepted
  output logic [`SLR_NPORTS-1:0]           tx_valid_o,     // Tx byte valid
  output slr_byte_t [`SLR_NPORTS-1:0]      tx_data_o,      // Tx byte
  output logic [`SLR_NPORTS-1:0]           tx_last_o,      // Tx frame end
  input  wire logic [`SLR_NPORTS-1:0]      tx_ready_i,     // Tx taken
  input  wire logic [`SLR_ADDR_W-1:0]      station_addr_i, // Own address
  input  wire logic [7:0]                  ext_offs_i,     // Extract pos
  input  wire logic [7:0]                  ins_offs_i,     // Insert pos
  input  wire logic                        ins_en_i,       // Insert on
  input  wire slr_byte_t                   ins_data_i,     // Insert byte
  output logic                             ext_valid_o,    // Extract pulse
  output slr_byte_t                        ext_data_o,     // Extract byte
  output logic [`SLR_NPORTS-1:0]           led_o           // Link/activity
);

  localparam int LV_DLY = `SLR_DLY_LV_CYC;
  localparam int CU_DLY = `SLR_DLY_CU_CYC;

  slr_state_t                       st;
  slr_state_t                       nxt;
  logic [`SLR_NPORTS-1:0]           rdy;
  logic [`SLR_NPORTS-1:0]           push;
  logic [`SLR_NPORTS-1:0]           pop;
  slr_entry_t [`SLR_NPORTS-1:0]     src_ent;
  slr_byte_t                        pd;
  logic                             hit;
  logic                             blink_end;

  // Accept a byte only when both ends are open and the target has room;
  // a two-entry buffer lets a full-rate stream pass while popping.
  always_comb begin
    for (int j = 0; j < `SLR_NPORTS; j++) begin
      slr_idx_t d;
      d = slr_next(slr_idx_t'(j), st.open);
      rdy[j] = st.open[j] && st.open[d] && (st.cnt[d] != 2'h2);
    end
  end

  assign rx_ready_o = rdy;

  // Address match is only known once both address bytes have passed,
  // so access offsets inside the address field (0 and 1) are never honoured.
  assign hit = (st.bidx > `SLR_ADDR_HI_POS) && (st.addr == station_addr_i);

  always_comb begin
    pd = rx_data_i[0];
    if (hit && ins_en_i && (st.bidx == ins_offs_i)) begin
      pd = ins_data_i;
    end
  end

  always_comb begin
    for (int k = 0; k < `SLR_NPORTS; k++) begin
      slr_idx_t s;
      s = slr_prev(slr_idx_t'(k), st.open);
      push[k] = st.open[k] && rx_valid_i[s] && rdy[s];
      if (s == 2'h0) begin
        src_ent[k] = {rx_last_i[0], pd};
      end else begin
        src_ent[k] = {rx_last_i[s], rx_data_i[s]};
      end
      pop[k] = tx_valid_o[k] && tx_ready_i[k];
    end
  end

  assign blink_end = (st.blink == 24'(FLICK_CYC - 1));

  always_comb begin
    logic [1:0] c;
    c = 2'h0;
    nxt = st;
    nxt.open = port_en_i & link_up_i;
    nxt.ext_v = 1'b0;
    if (blink_end) begin
      nxt.blink = 24'h000000;
      nxt.phase = ~st.phase;
      nxt.act = 4'h0;
    end else begin
      nxt.blink = st.blink + 24'h000001;
    end
    // Traffic seen in the closing cycle of a period still counts
    nxt.act = nxt.act | push | pop;
    for (int k = 0; k < `SLR_NPORTS; k++) begin
      c = st.cnt[k];
      if (pop[k]) begin
        nxt.buff[k][0] = st.buff[k][1];
        c = c - 2'h1;
      end
      if (push[k]) begin
        nxt.buff[k][c[0]] = src_ent[k];
        c = c + 2'h1;
      end
      // A port that loses its link drops what it still held
      if (!nxt.open[k]) c = 2'h0;
      nxt.cnt[k] = c;
    end
    if (rx_valid_i[0] && rdy[0]) begin
      if (rx_last_i[0]) begin
        nxt.bidx = 8'h00;
      end else if (st.bidx != `SLR_IDX_MAX) begin
        nxt.bidx = st.bidx + 8'h01;
      end
      if (st.bidx == `SLR_ADDR_LO_POS) nxt.addr[7:0] = rx_data_i[0];
      if (st.bidx == `SLR_ADDR_HI_POS) nxt.addr[15:8] = rx_data_i[0];
      if (hit && (st.bidx == ext_offs_i)) begin
        nxt.ext_v = 1'b1;
        nxt.ext_d = rx_data_i[0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  // Data leaves from the buffer head flop: one cycle through the port,
  // well inside the copper and differential delay budgets.
  always_comb begin
    for (int k = 0; k < `SLR_NPORTS; k++) begin
      tx_valid_o[k] = st.open[k] && (st.cnt[k] != 2'h0);
      tx_data_o[k] = st.buff[k][0][`SLR_BYTE_W-1:0];
      tx_last_o[k] = st.buff[k][0][`SLR_BYTE_W];
      led_o[k] = st.open[k] && (!st.act[k] || st.phase);
    end
  end

  assign ext_valid_o = st.ext_v;
  assign ext_data_o = st.ext_d;

  property p_open_link;
    @(posedge sys_clk_i) disable iff (rst_i)
      (port_en_i[0] && link_up_i[0]) |=> st.open[0];
  endproperty
  a_open_link: assert property (p_open_link) else $error("port 0 not opened on link");

  property p_closed_nolink;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!link_up_i[1]) |=> (!st.open[1] && !tx_valid_o[1]);
  endproperty
  a_closed_nolink: assert property (p_closed_nolink) else $error("unlinked port 1 active");

  property p_led_dark;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!link_up_i[2]) |=> !led_o[2];
  endproperty
  a_led_dark: assert property (p_led_dark) else $error("indicator lit without link");

  property p_led_steady;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st.open[3] && !st.act[3]) |-> led_o[3];
  endproperty
  a_led_steady: assert property (p_led_steady) else $error("idle link indicator not lit");

  property p_ring_order;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rx_valid_i[0] && rdy[0] && st.open[1] && link_up_i[1] && port_en_i[1])
        |=> tx_valid_o[1];
  endproperty
  a_ring_order: assert property (p_ring_order) else $error("byte not forwarded to port 1");

  property p_skip_closed;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st.open[0] && !st.open[1] && st.open[2] && rx_valid_i[0])
        |-> (push[2] == rdy[0]);
  endproperty
  a_skip_closed: assert property (p_skip_closed) else $error("closed port not skipped");

  property p_extract;
    @(posedge sys_clk_i) disable iff (rst_i)
      ext_valid_o |-> ($past(rx_valid_i[0]) && $past(hit)
                       && ($past(st.bidx) == $past(ext_offs_i))
                       && (ext_data_o == $past(rx_data_i[0])));
  endproperty
  a_extract: assert property (p_extract) else $error("extract without matching byte");

  property p_insert;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rx_valid_i[0] && rdy[0] && hit && ins_en_i && (st.bidx == ins_offs_i)
       && st.open[1] && port_en_i[1] && link_up_i[1] && (st.cnt[1] == 2'h0))
        |=> (tx_data_o[1] == $past(ins_data_i));
  endproperty
  a_insert: assert property (p_insert) else $error("inserted byte missing");

  property p_delay_lv;
    @(posedge sys_clk_i) disable iff (rst_i)
      (push[1] && (port_en_i[1] && link_up_i[1]))
        |-> ##[1:LV_DLY] tx_valid_o[1];
  endproperty
  a_delay_lv: assert property (p_delay_lv) else $error("forward delay over budget");

  property p_delay_cu;
    @(posedge sys_clk_i) disable iff (rst_i)
      (push[2] && tx_ready_i[2] && (port_en_i[2] && link_up_i[2]))
        |-> ##[1:CU_DLY] (tx_valid_o[2] || !st.open[2]);
  endproperty
  a_delay_cu: assert property (p_delay_cu) else $error("copper delay over budget");

  property p_no_overflow;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st.cnt[3] == 2'h2) |-> !push[3] || pop[3];
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("buffer overrun on port 3");

  // Reset must leave every port closed and every output quiet
  property p_rst_quiet;
    @(posedge sys_clk_i)
      rst_i |=> ((tx_valid_o == 4'h0) && (rx_ready_o == 4'h0) && (led_o == 4'h0) && !ext_valid_o);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");

  property p_unfitted;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!port_en_i[3]) |=> (!st.open[3] && !rx_ready_o[3] && !led_o[3]);
  endproperty
  a_unfitted: assert property (p_unfitted) else $error("unfitted port 3 opened");

  property p_closed_silent;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!st.open[0]) |-> (!tx_valid_o[0] && !rx_ready_o[0] && !push[0]);
  endproperty
  a_closed_silent: assert property (p_closed_silent) else $error("closed port 0 moves data");

  // A stalled port keeps its head byte steady until the sink takes it
  property p_tx_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      (tx_valid_o[0] && !tx_ready_i[0] && port_en_i[0] && link_up_i[0])
        |=> (tx_valid_o[0] && $stable(tx_data_o[0]) && $stable(tx_last_o[0]));
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("stalled byte changed");

  property p_addr_lo;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rx_valid_i[0] && rdy[0] && (st.bidx == `SLR_ADDR_LO_POS))
        |=> (st.addr[7:0] == $past(rx_data_i[0]));
  endproperty
  a_addr_lo: assert property (p_addr_lo) else $error("address low byte not captured");

  property p_addr_hi;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rx_valid_i[0] && rdy[0] && (st.bidx == `SLR_ADDR_HI_POS))
        |=> (st.addr[15:8] == $past(rx_data_i[0]));
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("address high byte not captured");

  // Byte position restarts with each frame so offsets stay frame-relative
  property p_frame_end;
    @(posedge sys_clk_i) disable iff (rst_i)
      (rx_valid_i[0] && rdy[0] && rx_last_i[0]) |=> (st.bidx == 8'h00);
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("byte index not restarted");

  property p_led_flicker;
    @(posedge sys_clk_i) disable iff (rst_i)
      (st.open[1] && st.act[1] && !st.phase) |-> !led_o[1];
  endproperty
  a_led_flicker: assert property (p_led_flicker) else $error("busy indicator not blinking");

  // Traffic in the closing cycle of a period must not be lost
  property p_act_set;
    @(posedge sys_clk_i) disable iff (rst_i)
      pop[2] |=> st.act[2];
  endproperty
  a_act_set: assert property (p_act_set) else $error("activity not recorded");

  // Extracted byte holds until the next extract
  property p_ext_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
      (!ext_valid_o) |-> $stable(ext_data_o);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("extract byte changed");

endmodule // slr_loop_router

/* File: tb/slr_peer.sv */
// Far-side sink standing for the four downstream neighbours of the loop router.
// Assumes the bench picks the stall mode; accept changes after the falling edge.
module slr_peer (
  input  wire logic       clk_i,   // Bench clock
  input  wire logic [1:0] mode_i,  // 0 ready, 1 random stall, 2 stalled
  output logic      [3:0] ready_o  // Tx accept per port
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 21;
  initial ready_o = 4'hf;
  // Full duplex neighbours accept at any time unless told to stall
  always @(negedge clk_i) begin
    ready_o <= (mode_i == 2'h0) ? 4'hf : (mode_i == 2'h1) ? 4'($random(seed)) : 4'h0;
  end
endmodule // slr_peer

/* File: tb/tb_top.sv */
// Self-checking bench of the loop router with a sink model on all tx streams.
// Assumes one 250 MHz clock; inputs change at the falling edge.
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  import slr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FC = 8;
  logic            sys_clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic      [3:0] port_en_i, link_up_i, rx_valid_i, rx_last_i, rx_ready_o;
  logic      [3:0] tx_valid_o, tx_last_o, tx_ready_i, led_o;
  slr_byte_t [3:0] rx_data_i, tx_data_o;
  logic     [15:0] station_addr_i;
  logic      [7:0] ext_offs_i, ins_offs_i;
  logic            ins_en_i, ext_valid_o;
  slr_byte_t       ins_data_i, ext_data_o, eb;
  logic      [1:0] mode;
  logic     [10:0] ev, exp_q[$];
  slr_byte_t       ext_q[$];
  int              seed = 21;
  int              mismatches, tests_run, dark, cnt;

  always #2 sys_clk_i = ~sys_clk_i;

  slr_loop_router #(.FLICK_CYC(FC)) u_dut (.sys_clk_i, .rst_i, .port_en_i, .link_up_i, .rx_valid_i,
    .rx_data_i, .rx_last_i, .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i,
    .station_addr_i, .ext_offs_i, .ins_offs_i, .ins_en_i, .ins_data_i, .ext_valid_o, .ext_data_o, .led_o);
  slr_peer u_peer (.clk_i(sys_clk_i), .mode_i(mode), .ready_o(tx_ready_i));

  function automatic int nxt(int j, logic [3:0] op);
    for (int d = 1; d < 4; d++) if (op[(j + d) % 4]) return (j + d) % 4;
    return j;
  endfunction

  task automatic test_done;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic bail;
    mismatches++;
    test_done();
  endtask

  // Outputs are settled 1 ns after the falling edge until the next rising edge
  always @(negedge sys_clk_i) begin
    #1;
    for (int k = 0; k < 4; k++) if ((tx_valid_o[k] & tx_ready_i[k]) === 1'b1) begin
      if (exp_q.size() == 0) bail();
      ev = exp_q.pop_front();
      `CHK("tx", ev, {2'(k), tx_last_o[k], tx_data_o[k]})
    end
    if (ext_valid_o === 1'b1) begin
      if (ext_q.size() == 0) bail();
      eb = ext_q.pop_front();
      `CHK("ext", eb, ext_data_o)
    end
    if (|(link_up_i & port_en_i & ~led_o) === 1'b1) dark++;
  end

  task automatic send(int j, slr_byte_t d, logic l);
    int n;
    @(negedge sys_clk_i);
    rx_valid_i[j] = 1'b1;
    rx_data_i[j] = d;
    rx_last_i[j] = l;
    for (n = 0; n < 40; n++) begin
      #1;
      if (rx_ready_o[j] === 1'b1) break;
      @(negedge sys_clk_i);
    end
    if (n == 40) bail();
    @(negedge sys_clk_i);
    rx_valid_i[j] = 1'b0;
    rx_data_i[j] = ~d;
  endtask

  task automatic drain;
    for (int n = 0; n < 300 && exp_q.size() > 0; n++) @(negedge sys_clk_i);
    if (exp_q.size() > 0) bail();
  endtask

  // Address bytes lead the frame; a hit enables extract and insert on port 0
  task automatic frame(int j, int len, bit hit);
    slr_byte_t   d;
    logic [15:0] a;
    int          dst;
    a = hit ? station_addr_i : ~station_addr_i;
    dst = nxt(j, link_up_i & port_en_i);
    for (int k = 0; k < len; k++) begin
      d = (k == 0) ? a[7:0] : (k == 1) ? a[15:8] : 8'($random(seed));
      if (j == 0 && hit && k == ext_offs_i) ext_q.push_back(d);
      exp_q.push_back({2'(dst), k == len - 1, (j == 0 && hit && ins_en_i && k == ins_offs_i) ? ins_data_i : d});
      send(j, d, k == len - 1);
    end
    drain();
  endtask

  initial begin
    {port_en_i, link_up_i, rx_valid_i, rx_last_i, ins_en_i, mode} = '0;
    rx_data_i = '0;
    station_addr_i = 16'($random(seed));
    ext_offs_i = 8'h02;
    ins_offs_i = 8'h02;
    ins_data_i = 8'($random(seed));
    repeat (16) @(negedge sys_clk_i);
    rst_i = 1'b0;
    `CHK("rst", 13'h0, {tx_valid_o, rx_ready_o, led_o, ext_valid_o})
    link_up_i = 4'hf;
    repeat (3) @(negedge sys_clk_i);
    `CHK("unfit", 8'h0, {rx_ready_o, led_o})
    for (int c = 0; c < 6; c++) begin
      port_en_i = (c == 0) ? 4'hf : (c == 1) ? 4'h4 : 4'($random(seed)) | 4'h1;
      link_up_i = (c < 2) ? 4'hf : 4'($random(seed)) | 4'h1;
      ins_en_i = c[0];
      mode = 2'(c % 2);
      repeat (3 * FC) @(negedge sys_clk_i);
      `CHK("led", link_up_i & port_en_i, led_o)
      `CHK("closed", 4'h0, rx_ready_o & ~(link_up_i & port_en_i))
      for (int j = 0; j < 4; j++) if ((link_up_i[j] & port_en_i[j]) === 1'b1) frame(j, 4 + j, c[1]);
    end
    {port_en_i, link_up_i} = 8'hff;
    mode = 2'h2;
    // Earlier frames leave their end flag up; the fill bytes are mid-frame
    rx_last_i = 4'h0;
    repeat (3) @(negedge sys_clk_i);
    rx_valid_i[3] = 1'b1;
    // Held valid with the sink stalled: exactly the two buffer entries fill
    repeat (6) begin
      rx_data_i[3] = 8'h10 + 8'(cnt);
      #1;
      if (rx_ready_o[3] === 1'b1) begin
        exp_q.push_back({2'h0, 1'b0, 8'h10 + 8'(cnt)});
        cnt++;
      end
      @(negedge sys_clk_i);
    end
    rx_valid_i[3] = 1'b0;
    `CHK("fill", 2, cnt)
    mode = 2'h1;
    drain();
    dark = 0;
    frame(3, 40, 1'b0);
    `CHK("flicker", 1'b1, dark > 0)
    `CHK("ext_left", 0, ext_q.size())
    test_done();
  end
endmodule // tb_top
